// File: src/bhp_host_port.sv
// binary host port: parallel computer interface card with command/flag handshake
// toward the computer and instruction/operation-complete handshake on the backplane.
// assumes all inputs synchronous to sys_clk; open-drain backplane lines are
// resolved outside from the output enables.
// Summary of operation
// - card raises flag after accepting an instruction
// - separate or shared data lines, only one transfer at a time
// - host word width is 8 or 16 bits; 12-bit hosts use 8
// - flag drops at once when the command strobe drops
// - in command mode every host word is an instruction
// - data mode takes two 16-bit or four 8-bit words
// - multiword transfers move the most significant word first
// - exactly two instructions enter data mode: host output and host input
// - after the last data word the card returns to command mode
// - command mode forwards each instruction to backplane and decodes it too
// - instruction bits are positive-true
// - own command 0 resets backplane and clears error buffer
// - command 0 to another card only clears error buffer
// - own command 1 issues simultaneous sample on backplane
// - own command 2 drives I/O buffer onto backplane data bus
// - command 2 to another card captures its backplane data into buffer
// - own command 3 sends buffer data and error bits to computer
// - command 3 to another card loads it from buffer over backplane
// - own command 4 loads computer data into I/O buffer
// - system reset acts as command 0; sample to another card and own codes above 4 do nothing
// - data source pulls data-valid low to mark valid data
// - each card releases operation-complete when able; receiver after accepting
// - all released then instruction-valid returns high, cards pull complete low
`timescale 1ns/100ps
`default_nettype none

module bhp_host_port (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  // computer side
  input  wire logic        wide_mode,
  input  wire logic        host_cmd,
  output logic             host_flag,
  input  wire logic [15:0] host_data_in,
  output logic [15:0]      host_data_out,
  output logic             host_data_oe,
  output logic [3:0]       host_err_out,
  // backplane instruction handshake
  output logic [7:0]       bp_instr,
  output logic             instruction_valid_line_n,
  input  wire logic        operation_complete_line_in,
  output logic             operation_complete_line_oe,
  input  wire logic        backplane_data_valid_n_in,
  output logic             backplane_data_valid_oe,
  // backplane data
  input  wire logic [31:0] bp_data_in,
  input  wire logic [3:0]  bp_err_in,
  output logic [31:0]      bp_data_out,
  output logic             bp_data_oe,
  // backplane control
  input  wire logic        bp_sys_reset,
  output logic             bp_reset_out,
  output logic             bp_sample_out
);

  bhp_pkg::bhp_state_t state_r;
  bhp_pkg::bhp_mode_t  mode_r;
  logic [7:0]          instr_r;
  logic [2:0]          words_left_r;
  logic [31:0]         io_buf_r;
  logic [31:0]         host_sh_r;
  logic [3:0]          err_buf_r;
  logic                flag_r;
  logic                valid_n_r;
  logic                cmpl_oe_r;
  logic                dvalid_oe_r;
  logic                bp_oe_r;
  logic [31:0]         bp_out_r;
  logic [15:0]         host_out_r;
  logic                host_oe_r;
  logic                bp_reset_r;
  logic                bp_sample_r;
  logic                got_data_r;

  // decode of the latched instruction, positive-true bits taken as they stand
  logic [3:0] cmd_code;
  logic [3:0] cmd_addr;
  logic       to_self;
  logic       drives_bp;
  logic       takes_bp;
  logic       host_word;
  logic       last_word;
  logic       bp_done;

  assign cmd_code  = instr_r[bhp_pkg::CMD_LSB +: bhp_pkg::CMD_W];
  assign cmd_addr  = instr_r[bhp_pkg::ADDR_LSB +: bhp_pkg::ADDR_W];
  assign to_self   = (cmd_addr == bhp_pkg::SELF_ADDR);
  // this card is the data source for own 2 and foreign 3
  assign drives_bp = (to_self && cmd_code == bhp_pkg::CMD_BUF_BP) ||
                     (!to_self && cmd_code == bhp_pkg::CMD_BUF_HOST);
  // this card receives data put up by another card
  assign takes_bp  = !to_self && cmd_code == bhp_pkg::CMD_BUF_BP;
  // a strobe while idle and not yet served starts one operation
  assign host_word = (state_r == bhp_pkg::BHP_ST_IDLE) && host_cmd;
  assign last_word = (words_left_r == 3'h1);
  // every card, this one included, has let operation-complete go high
  assign bp_done   = !cmpl_oe_r && operation_complete_line_in;

  // flag is cut off combinationally the moment the strobe falls
  assign host_flag = flag_r && host_cmd;

  assign bp_instr                   = instr_r;
  assign instruction_valid_line_n   = valid_n_r;
  assign operation_complete_line_oe = cmpl_oe_r;
  assign backplane_data_valid_oe    = dvalid_oe_r;
  assign bp_data_out                = bp_out_r;
  assign bp_data_oe                 = bp_oe_r;
  assign host_data_out              = host_out_r;
  assign host_data_oe               = host_oe_r;
  assign host_err_out               = err_buf_r;
  assign bp_reset_out               = bp_reset_r;
  assign bp_sample_out              = bp_sample_r;

  // handshake sequencer: one operation in flight, next strobe only after the last drops
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= bhp_pkg::BHP_ST_IDLE;
    end else if (clk_en) begin
      case (state_r)
        bhp_pkg::BHP_ST_IDLE: begin
          if (host_cmd && mode_r == bhp_pkg::BHP_MODE_CMD) begin
            state_r <= bhp_pkg::BHP_ST_BP_WAIT;
          end else if (host_cmd) begin
            state_r <= bhp_pkg::BHP_ST_FLAG;
          end
        end
        bhp_pkg::BHP_ST_BP_WAIT: begin
          if (bp_done) begin
            state_r <= bhp_pkg::BHP_ST_BP_END;
          end
        end
        bhp_pkg::BHP_ST_BP_END: begin
          state_r <= bhp_pkg::BHP_ST_FLAG;
        end
        bhp_pkg::BHP_ST_FLAG: begin
          // wait for the strobe to fall so one strobe is never served twice
          if (!host_cmd) begin
            state_r <= bhp_pkg::BHP_ST_IDLE;
          end
        end
        default: begin
          state_r <= bhp_pkg::BHP_ST_IDLE;
        end
      endcase
    end
  end

  // flag register: set on completion, held until the strobe drops
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      flag_r <= 1'b0;
    end else if (clk_en) begin
      if (!host_cmd) begin
        flag_r <= 1'b0;
      end else if (state_r == bhp_pkg::BHP_ST_BP_END) begin
        flag_r <= 1'b1;
      end else if (host_word && mode_r != bhp_pkg::BHP_MODE_CMD) begin
        flag_r <= 1'b1;
      end
    end
  end

  // instruction latch: in command mode every host word is taken as an instruction
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      instr_r <= bhp_pkg::INSTR_RST;
    end else if (clk_en) begin
      if (host_word && mode_r == bhp_pkg::BHP_MODE_CMD) begin
        instr_r <= host_data_in[7:0];
      end
    end
  end

  // instruction-valid: low while the instruction is on the backplane
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      valid_n_r <= 1'b1;
    end else if (clk_en) begin
      if (host_word && mode_r == bhp_pkg::BHP_MODE_CMD) begin
        valid_n_r <= 1'b0;
      end else if (state_r == bhp_pkg::BHP_ST_BP_WAIT && bp_done) begin
        valid_n_r <= 1'b1;
      end
    end
  end

  // capture marker for a receive; cleared as soon as the sequencer leaves the backplane wait
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      got_data_r <= 1'b0;
    end else if (clk_en) begin
      if (state_r != bhp_pkg::BHP_ST_BP_WAIT) begin
        got_data_r <= 1'b0;
      end else if (takes_bp && !backplane_data_valid_n_in) begin
        got_data_r <= 1'b1;
      end
    end
  end

  // operation-complete: held low between instructions, released when this card is done
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cmpl_oe_r <= 1'b1;
    end else if (clk_en) begin
      if (state_r == bhp_pkg::BHP_ST_BP_WAIT && !bp_done) begin
        // a receiver lets go only once the data has been taken
        if (!takes_bp || got_data_r) begin
          cmpl_oe_r <= 1'b0;
        end
      end else begin
        cmpl_oe_r <= 1'b1;
      end
    end
  end

  // backplane data drive and data-valid: source puts data up and pulls valid low together
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bp_out_r    <= bhp_pkg::BUF_RST;
      bp_oe_r     <= 1'b0;
      dvalid_oe_r <= 1'b0;
    end else if (clk_en) begin
      if (state_r == bhp_pkg::BHP_ST_BP_WAIT && drives_bp && !bp_done) begin
        bp_out_r    <= io_buf_r;
        bp_oe_r     <= 1'b1;
        dvalid_oe_r <= 1'b1;
      end else if (state_r != bhp_pkg::BHP_ST_BP_WAIT || bp_done) begin
        bp_oe_r     <= 1'b0;
        dvalid_oe_r <= 1'b0;
      end
    end
  end

  // backplane reset and sample strobes, one cycle each at the end of the instruction
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bp_reset_r  <= 1'b0;
      bp_sample_r <= 1'b0;
    end else if (clk_en) begin
      bp_reset_r  <= 1'b0;
      bp_sample_r <= 1'b0;
      if (state_r == bhp_pkg::BHP_ST_BP_END && to_self) begin
        bp_reset_r  <= (cmd_code == bhp_pkg::CMD_RESET);
        bp_sample_r <= (cmd_code == bhp_pkg::CMD_SAMPLE);
      end
    end
  end

  // error-bit buffer: loaded with received data, cleared by any command 0 or system reset
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      err_buf_r <= bhp_pkg::ERR_RST;
    end else if (clk_en) begin
      if (bp_sys_reset) begin
        err_buf_r <= bhp_pkg::ERR_RST;
      end else if (state_r == bhp_pkg::BHP_ST_BP_END
                   && cmd_code == bhp_pkg::CMD_RESET) begin
        err_buf_r <= bhp_pkg::ERR_RST;
      end else if (state_r == bhp_pkg::BHP_ST_BP_WAIT && takes_bp
                   && !backplane_data_valid_n_in && !got_data_r) begin
        err_buf_r <= bp_err_in;
      end
    end
  end

  // mode and word counter: only own 3 and own 4 enter data mode
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mode_r       <= bhp_pkg::BHP_MODE_CMD;
      words_left_r <= 3'h0;
    end else if (clk_en) begin
      if (bp_sys_reset) begin
        // a system reset aborts a half-done data transfer
        mode_r       <= bhp_pkg::BHP_MODE_CMD;
        words_left_r <= 3'h0;
      end else if (state_r == bhp_pkg::BHP_ST_BP_END && to_self) begin
        words_left_r <= wide_mode ? bhp_pkg::WORDS_WIDE : bhp_pkg::WORDS_NARROW;
        if (cmd_code == bhp_pkg::CMD_BUF_HOST) begin
          mode_r <= bhp_pkg::BHP_MODE_TO_HOST;
        end else if (cmd_code == bhp_pkg::CMD_HOST_BUF) begin
          mode_r <= bhp_pkg::BHP_MODE_FROM_HOST;
        end
      end else if (host_word && mode_r != bhp_pkg::BHP_MODE_CMD) begin
        words_left_r <= words_left_r - 3'h1;
        if (last_word) begin
          mode_r <= bhp_pkg::BHP_MODE_CMD;
        end
      end
    end
  end

  // I/O buffer: filled from the backplane or shifted in from the host, msw first
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      io_buf_r <= bhp_pkg::BUF_RST;
    end else if (clk_en) begin
      if (state_r == bhp_pkg::BHP_ST_BP_WAIT && takes_bp
          && !backplane_data_valid_n_in && !got_data_r) begin
        io_buf_r <= bp_data_in;
      end else if (host_word && mode_r == bhp_pkg::BHP_MODE_FROM_HOST) begin
        // earlier words move up, so the first word sent lands on top
        if (wide_mode) begin
          io_buf_r <= {io_buf_r[15:0], host_data_in};
        end else begin
          io_buf_r <= {io_buf_r[23:0], host_data_in[7:0]};
        end
      end
    end
  end

  // host readback: a copy of the buffer is shifted out so the buffer itself survives
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      host_sh_r  <= bhp_pkg::BUF_RST;
      host_out_r <= 16'h0000;
      host_oe_r  <= 1'b0;
    end else if (clk_en) begin
      if (state_r == bhp_pkg::BHP_ST_BP_END && to_self
          && cmd_code == bhp_pkg::CMD_BUF_HOST) begin
        host_sh_r <= io_buf_r;
      end else if (host_word && mode_r == bhp_pkg::BHP_MODE_TO_HOST) begin
        host_oe_r <= 1'b1;
        if (wide_mode) begin
          host_out_r <= host_sh_r[31:16];
          host_sh_r  <= {host_sh_r[15:0], 16'h0000};
        end else begin
          host_out_r <= {8'h00, host_sh_r[31:24]};
          host_sh_r  <= {host_sh_r[23:0], 8'h00};
        end
      end else if (!host_cmd) begin
        // word stays up while the flag does, shared lines freed afterwards
        host_oe_r <= 1'b0;
      end
    end
  end

endmodule : bhp_host_port

`default_nettype wire

// File: src/bhp_pkg.sv
// package for the binary host port: instruction fields, command codes,
// transfer sizes and the enumerations shared by the design.
// assumes a single 100 MHz clock domain and positive-true instruction bits.
package bhp_pkg;

  // clock figure, kept for reference by anything that needs a time base
  localparam int unsigned CLK_PERIOD_NS = 10;

  // instruction byte layout: low nibble is the command, high nibble the card address
  localparam int unsigned INSTR_W     = 8;
  localparam int unsigned CMD_LSB     = 0;
  localparam int unsigned CMD_W       = 4;
  localparam int unsigned ADDR_LSB    = 4;
  localparam int unsigned ADDR_W      = 4;

  // backplane address of this card (positive-true code 0 in the high nibble)
  localparam logic [3:0] SELF_ADDR    = 4'h0;

  // command codes in the low nibble
  localparam logic [3:0] CMD_RESET    = 4'h0;
  localparam logic [3:0] CMD_SAMPLE   = 4'h1;
  localparam logic [3:0] CMD_BUF_BP   = 4'h2;
  localparam logic [3:0] CMD_BUF_HOST = 4'h3;
  localparam logic [3:0] CMD_HOST_BUF = 4'h4;

  // data widths and word counts of one data-mode transfer
  localparam int unsigned HOST_W      = 16;
  localparam int unsigned BUF_W       = 32;
  localparam int unsigned ERR_W       = 4;
  localparam logic [2:0]  WORDS_WIDE  = 3'h2;
  localparam logic [2:0]  WORDS_NARROW = 3'h4;

  // reset values
  localparam logic [31:0] BUF_RST     = 32'h0000_0000;
  localparam logic [3:0]  ERR_RST     = 4'h0;
  localparam logic [7:0]  INSTR_RST   = 8'h00;

  // handshake sequencer
  typedef enum logic [1:0] {
    BHP_ST_IDLE,
    BHP_ST_BP_WAIT,
    BHP_ST_BP_END,
    BHP_ST_FLAG
  } bhp_state_t;

  // command mode or one of the two data modes
  typedef enum logic [1:0] {
    BHP_MODE_CMD,
    BHP_MODE_FROM_HOST,
    BHP_MODE_TO_HOST
  } bhp_mode_t;

endpackage : bhp_pkg

// File: verification/bhp_host_model.sv
// computer side model: strobes one word at a time and waits for the flag
// assumes the bench calls strobe_word and that the port runs on sys_clk
`timescale 1ns/100ps
`default_nettype none

module bhp_host_model (
  input  wire logic        sys_clk,
  input  wire logic        host_flag,
  input  wire logic [15:0] host_data_out,
  output logic             host_cmd,
  output logic [15:0]      host_data_in
);
  // idle computer: strobe low, output register at rest
  initial begin
    host_cmd = 1'b0;
    host_data_in = 16'h0000;
  end

  // one operation at a time: strobe up with the word, hold past the flag
  task automatic strobe_word(input logic [15:0] w, output logic [15:0] rd, output logic ok);
    int n;
    ok = 1'b0;
    rd = 16'h0000;
    @(negedge sys_clk);
    host_cmd = 1'b1;
    host_data_in = w;
    for (n = 0; n < 300 && !ok; n++) begin
      @(negedge sys_clk);
      ok = (host_flag === 1'b1);
    end
    rd = host_data_out;
    @(posedge sys_clk);
    @(negedge sys_clk);
    host_cmd = 1'b0;
    host_data_in = ~w; // released register must not look like the old word
    @(negedge sys_clk);
  endtask : strobe_word
endmodule : bhp_host_model

`default_nettype wire

// File: verification/bhp_port_monitor.sv
// checker for the binary host port: flag and backplane handshake relations
// assumes it is bound onto bhp_host_port, all inputs synchronous to sys_clk
`timescale 1ns/100ps
`default_nettype none

module bhp_port_monitor (
  input wire logic       sys_clk,
  input wire logic       resetn,
  input wire logic       clk_en,
  input wire logic       host_cmd,
  input wire logic       host_flag,
  input wire logic [3:0] host_err_out,
  input wire logic [7:0] bp_instr,
  input wire logic       instruction_valid_line_n,
  input wire logic       operation_complete_line_in,
  input wire logic       operation_complete_line_oe,
  input wire logic       backplane_data_valid_oe,
  input wire logic       bp_data_oe,
  input wire logic       bp_sys_reset,
  input wire logic       bp_reset_out,
  input wire logic       bp_sample_out
);
  default clocking mon_cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // instruction still up while every card has let complete go
  sequence instr_done;
    !instruction_valid_line_n && operation_complete_line_in && clk_en;
  endsequence
  // valid line returns high, then this card pulls complete low again
  sequence instr_close;
    instruction_valid_line_n ##1 operation_complete_line_oe;
  endsequence

  flag_gated_a: assert property (!host_cmd |-> !host_flag)
    else $error("flag seen without command strobe");
  flag_stands_a: assert property ((host_flag ##1 host_cmd) |-> host_flag)
    else $error("flag dropped while strobe still high");
  flag_after_instr_a: assert property ($rose(host_flag) |-> instruction_valid_line_n)
    else $error("flag raised while instruction still on backplane");
  instr_close_a: assert property (instr_done |=> instr_close)
    else $error("instruction not closed after complete released");
  instr_steady_a: assert property
    (!instruction_valid_line_n && $past(!instruction_valid_line_n) |-> $stable(bp_instr))
    else $error("backplane instruction changed while valid");
  dav_has_data_a: assert property (backplane_data_valid_oe |-> bp_data_oe)
    else $error("data valid pulled without data driven");
  source_release_a: assert property
    (bp_data_oe && !instruction_valid_line_n |-> !operation_complete_line_oe)
    else $error("data source still holds complete low");
  reset_pulse_a: assert property
    ($rose(bp_reset_out) |-> (bp_instr == 8'h00) ##1 !bp_reset_out)
    else $error("backplane reset pulse without own command 0");
  sample_pulse_a: assert property
    ($rose(bp_sample_out) |-> (bp_instr == 8'h01) ##1 !bp_sample_out)
    else $error("sample pulse without own command 1");
  sys_reset_clear_a: assert property (bp_sys_reset && clk_en |=> host_err_out == 4'h0)
    else $error("error bits kept after system reset");
endmodule : bhp_port_monitor

bind bhp_host_port bhp_port_monitor u_mon (
  .sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .host_cmd(host_cmd),
  .host_flag(host_flag), .host_err_out(host_err_out), .bp_instr(bp_instr),
  .instruction_valid_line_n(instruction_valid_line_n),
  .operation_complete_line_in(operation_complete_line_in),
  .operation_complete_line_oe(operation_complete_line_oe),
  .backplane_data_valid_oe(backplane_data_valid_oe), .bp_data_oe(bp_data_oe),
  .bp_sys_reset(bp_sys_reset), .bp_reset_out(bp_reset_out), .bp_sample_out(bp_sample_out));

`default_nettype wire

// File: verification/tb.sv
// bench for the binary host port: command, data-mode and backplane scenarios
// assumes the host model drives the computer side; the other card is modelled here
`timescale 1ns/100ps
`default_nettype none

module tb;
  logic        sys_clk, resetn, wide_mode, host_cmd, host_flag, host_data_oe;
  logic [15:0] host_data_in, host_data_out;
  logic [3:0]  host_err_out, bp_err_in;
  logic [7:0]  bp_instr;
  logic        instruction_valid_line_n, operation_complete_line_oe, backplane_data_valid_oe;
  logic        bp_data_oe, bp_sys_reset, bp_reset_out, bp_sample_out, other_cmpl, other_dvalid;
  logic [31:0] bp_data_in, bp_data_out, bp_seen;
  logic        rst_seen, smp_seen, oe_seen, clk_en;
  int          bad_count, total_checks, cycles;
  wire logic   operation_complete_line_in;
  wire logic   backplane_data_valid_n_in;

  // wired-low backplane lines resolved from both cards
  assign operation_complete_line_in = !(operation_complete_line_oe || other_cmpl);
  assign backplane_data_valid_n_in = !(backplane_data_valid_oe || other_dvalid);

  bhp_host_port dut (
    .sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .wide_mode(wide_mode),
    .host_cmd(host_cmd), .host_flag(host_flag), .host_data_in(host_data_in),
    .host_data_out(host_data_out), .host_data_oe(host_data_oe), .host_err_out(host_err_out),
    .bp_instr(bp_instr), .instruction_valid_line_n(instruction_valid_line_n),
    .operation_complete_line_in(operation_complete_line_in),
    .operation_complete_line_oe(operation_complete_line_oe),
    .backplane_data_valid_n_in(backplane_data_valid_n_in),
    .backplane_data_valid_oe(backplane_data_valid_oe), .bp_data_in(bp_data_in),
    .bp_err_in(bp_err_in), .bp_data_out(bp_data_out), .bp_data_oe(bp_data_oe),
    .bp_sys_reset(bp_sys_reset), .bp_reset_out(bp_reset_out), .bp_sample_out(bp_sample_out));

  bhp_host_model host (
    .sys_clk(sys_clk), .host_flag(host_flag), .host_data_out(host_data_out),
    .host_cmd(host_cmd), .host_data_in(host_data_in));

  // clock at 100 MHz
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // sticky capture of one-cycle pulses and driven backplane data
  always @(posedge sys_clk) begin
    if (bp_reset_out) rst_seen <= 1'b1;
    if (bp_sample_out) smp_seen <= 1'b1;
    if (host_data_oe) oe_seen <= 1'b1;
    if (bp_data_oe) bp_seen <= bp_data_out;
  end

  // hang guard: the scenarios need a few hundred cycles at most
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      complete_run();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic xfer(input logic [15:0] w, output logic [15:0] rd);
    logic ok;
    host.strobe_word(w, rd, ok);
    check(ok, 1'b1);
  endtask : xfer

  task automatic t_reset_state();
    check(host_flag, 1'b0);
    check({instruction_valid_line_n, operation_complete_line_oe}, 2'b11);
    check(host_err_out, 4'h0);
  endtask : t_reset_state

  // flag waits while the other card still holds complete low; a frozen clock takes nothing
  task automatic t_sample_stall();
    logic [15:0] rd;
    other_cmpl = 1'b1;
    smp_seen = 1'b0;
    clk_en = 1'b0;
    fork
      xfer(16'h0001, rd);
      begin
        repeat (6) @(negedge sys_clk);
        check(instruction_valid_line_n, 1'b1);
        clk_en = 1'b1;
        repeat (12) @(negedge sys_clk);
        check(host_flag, 1'b0);
        check(bp_instr, 8'h01);
        other_cmpl = 1'b0;
      end
    join
    check(smp_seen, 1'b1);
    smp_seen = 1'b0;
    rst_seen = 1'b0;
    xfer(16'h0005, rd);
    check({smp_seen, rst_seen}, 2'b00);
  endtask : t_sample_stall

  // host loads the buffer, then it is driven out for own 2 and other 3
  task automatic t_load_and_drive(input logic wide, input logic [31:0] val);
    logic [15:0] rd;
    int i;
    wide_mode = wide;
    xfer(16'h0004, rd);
    for (i = (wide ? 1 : 3); i >= 0; i--) begin
      if (wide) xfer(val[i*16 +: 16], rd);
      else xfer({8'h00, val[i*8 +: 8]}, rd);
    end
    smp_seen = 1'b0;
    xfer(16'h0001, rd);
    check(smp_seen, 1'b1);
    bp_seen = 32'h0000_0000;
    xfer(16'h0002, rd);
    check(bp_seen, val);
    bp_seen = 32'h0000_0000;
    xfer(16'h0013, rd);
    check(bp_seen, val);
  endtask : t_load_and_drive

  // card 1 sources data and error bits, this card captures them
  task automatic cap(input logic [31:0] val, input logic [3:0] err);
    logic [15:0] rd;
    bp_data_in = val;
    bp_err_in = err;
    other_dvalid = 1'b1;
    xfer(16'h0012, rd);
    other_dvalid = 1'b0;
    bp_data_in = ~val;
    bp_err_in = ~err;
    check(host_err_out, err);
  endtask : cap

  task automatic t_capture_read(input logic wide, input logic [31:0] val, input logic [3:0] err);
    logic [15:0] rd;
    int i;
    cap(val, err);
    wide_mode = wide;
    xfer(16'h0003, rd);
    oe_seen = 1'b0;
    for (i = (wide ? 1 : 3); i >= 0; i--) begin
      xfer(16'h0000, rd);
      if (wide) check(rd, val[i*16 +: 16]);
      else check(rd, {8'h00, val[i*8 +: 8]});
    end
    check({oe_seen, host_data_oe}, 2'b10);
  endtask : t_capture_read

  // the three ways of clearing the error bits
  task automatic t_err_clear();
    logic [15:0] rd;
    cap(32'h0000_1111, 4'h5);
    rst_seen = 1'b0;
    xfer(16'h0010, rd);
    check({rst_seen, host_err_out}, 5'h00);
    cap(32'h0000_2222, 4'h6);
    bp_sys_reset = 1'b1;
    @(negedge sys_clk);
    bp_sys_reset = 1'b0;
    @(negedge sys_clk);
    check(host_err_out, 4'h0);
    cap(32'h0000_3333, 4'h9);
    // repeated zeros flush a half-done data transfer before one lands as command 0
    xfer(16'h0004, rd);
    repeat (wide_mode ? 2 : 4) xfer(16'h0000, rd);
    check({rst_seen, host_err_out}, 5'h09);
    xfer(16'h0000, rd);
    check({rst_seen, host_err_out}, 5'h10);
  endtask : t_err_clear

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  // main sequence
  initial begin
    resetn = 1'b0;
    wide_mode = 1'b1;
    bp_data_in = 32'h0000_0000;
    bp_err_in = 4'h0;
    bp_sys_reset = 1'b0;
    other_cmpl = 1'b0;
    other_dvalid = 1'b0;
    clk_en = 1'b1;
    {rst_seen, smp_seen, oe_seen, bp_seen} = '0;
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    resetn = 1'b1;
    t_reset_state();
    t_sample_stall();
    t_load_and_drive(1'b1, 32'h1234_5678);
    t_load_and_drive(1'b0, 32'h0401_02a5);
    t_capture_read(1'b1, 32'hcafe_0123, 4'ha);
    t_capture_read(1'b0, 32'h89ab_cdef, 4'h3);
    t_err_clear();
    complete_run();
  end
endmodule : tb

`default_nettype wire
